//--- design/can_buf_ctl_pkg.sv
// constants shared by the buffer status and transmit control block
package can_buf_ctl_pkg;

	// --------------------
	// sizes
	// --------------------
	localparam int NUM_RX_BUFS    = 32;
	localparam int NUM_TR_BUFS    = 8;
	localparam int NUM_MASKS      = 3;
	localparam int NUM_FILTERS    = 16;
	localparam int EID_W          = 16;
	localparam int ADDR_W         = 8;

	// --------------------
	// register byte offsets
	// --------------------
	localparam logic [ADDR_W-1:0] OFS_EXT_ID_MASK_0   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_EXT_ID_MASK_1   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_EXT_ID_MASK_2   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RX_FULL_LOW     = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_RX_FULL_HIGH    = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_RX_OVF_LOW      = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_RX_OVF_HIGH     = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_PAIR_CTL_0      = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_PAIR_CTL_3      = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_MASK_SOURCE_SEL = 8'h2c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS      = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK        = 8'h34;

	// --------------------
	// buffer control byte field positions
	// --------------------
	localparam int CTL_DIR_BIT   = 7;
	localparam int CTL_ABT_BIT   = 6;
	localparam int CTL_LARB_BIT  = 5;
	localparam int CTL_ERR_BIT   = 4;
	localparam int CTL_REQ_BIT   = 3;
	localparam int CTL_RTR_BIT   = 2;
	localparam int CTL_PRI_LSB   = 0;

	// --------------------
	// interrupt status bit positions
	// --------------------
	localparam int IRQ_RX_STORED = 0;
	localparam int IRQ_RX_OVF    = 1;
	localparam int IRQ_TX_DONE   = 2;
	localparam int IRQ_TX_ABT    = 3;
	localparam int IRQ_TX_LARB   = 4;
	localparam int IRQ_TX_ERR    = 5;
	localparam int IRQ_W         = 6;

	// --------------------
	// reset values
	// --------------------
	localparam logic [15:0] RST_EXT_ID_MASK = 16'h0000;
	localparam logic [15:0] RST_FLAGS       = 16'h0000;
	localparam logic [15:0] RST_PAIR_CTL    = 16'h0000;
	localparam logic [31:0] RST_MASK_SEL    = 32'h0000_0000;

	// --------------------
	// encodings
	// --------------------
	typedef enum logic [1:0]
	{
		TX_EV_SUCCESS   = 2'b00,
		TX_EV_ABORTED   = 2'b01,
		TX_EV_LOST_ARB  = 2'b10,
		TX_EV_BUS_ERROR = 2'b11
	} tx_event_kind_t;

	localparam logic [1:0] MASK_SRC_NONE = 2'b11;

endpackage : can_buf_ctl_pkg

//--- design/can_buffer_status_tx_control.sv
// buffer status flags, buffer pair control and extended identifier masks
//
// Functional notes
// RL1: a mask bit of one compares the identifier bit; zero makes it don't care
// RL2: three independent extended identifier mask registers, selectable per filter
// RL3: 32 full flags over two registers, set by hardware on each message store
// RL4: software clears full and overflow flags by writing zero; one leaves them
// RL5: storing into an already full buffer sets that buffer's overflow flag
// RL6: each pair control register: low byte even buffer, high byte odd buffer
// RL7: direction bit one makes a transmit buffer, zero a receive buffer; resets zero
// RL8: read-only aborted flag tells whether the last transmission was aborted
// RL9: read-only lost arbitration flag set when the message loses arbitration
// RL10: read-only send error flag set on a bus error while sending
// RL11: software sets send request; hardware clears it after successful transmission
// RL12: writing zero to a set send request asks to abort that transmission
// RL13: with auto remote reply enabled, a received remote request sets send request
// RL14: pending transmit buffers ordered by priority, 11 highest down to 00
// RL15: aborted, lost arbitration and error flags clear when send request sets
// RL16: message identifiers, length and data live in DMA memory, not here
// RL17: filter mask source codes 00, 01, 10 pick masks 0 to 2; 11 no mask
// RL18: included identifier bits must equal the filter bits for a match
// RL19: an overflowing store keeps the unread contents of the full buffer
`timescale 1ns/1ps

module can_buffer_status_tx_control
	import can_buf_ctl_pkg::*;
(
	// clock and reset
	input  wire logic                   sys_clk_i,
	input  wire logic                   rst_n_i,
	// apb slave
	input  wire logic                   psel_i,
	input  wire logic                   penable_i,
	input  wire logic                   pwrite_i,
	input  wire logic [ADDR_W-1:0]      paddr_i,
	input  wire logic [31:0]            pwdata_i,
	output logic      [31:0]            prdata_o,
	output logic                        pready_o,
	output logic                        pslverr_o,
	// receive store from the protocol engine
	input  wire logic                   rx_store_i,
	input  wire logic [4:0]             rx_store_buf_i,
	output logic                        rx_store_accept_o,
	// remote request received for a transmit buffer
	input  wire logic                   remote_rx_i,
	input  wire logic [2:0]             remote_buf_i,
	// transmit outcome from the protocol engine
	input  wire logic                   tx_event_i,
	input  wire logic [2:0]             tx_event_buf_i,
	input  wire logic [1:0]             tx_event_kind_i,
	// transmit selection towards the protocol engine
	output logic                        tx_sel_valid_o,
	output logic      [2:0]             tx_sel_buf_o,
	output logic      [NUM_TR_BUFS-1:0] buf_is_tx_o,
	output logic      [NUM_TR_BUFS-1:0] abort_req_o,
	// acceptance comparison
	input  wire logic                   acc_valid_i,
	input  wire logic [3:0]             acc_filter_idx_i,
	input  wire logic [EID_W-1:0]       acc_filter_eid_i,
	input  wire logic [EID_W-1:0]       acc_id_i,
	output logic                        acc_done_o,
	output logic                        acc_match_o,
	// interrupt
	output logic                        irq_o
);

	// --------------------
	// reset release
	// --------------------
	logic rst_sync1_q;
	logic rst_n;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_sync1_q <= 1'b0;
			rst_n       <= 1'b0;
		end
		else
		begin
			rst_sync1_q <= 1'b1;
			rst_n       <= rst_sync1_q;
		end
	end

	// --------------------
	// functions
	// --------------------
	// effective mask for a filter from its two bit source code
	function automatic logic [EID_W-1:0] pick_mask(input logic [1:0] src,
		input logic [NUM_MASKS*EID_W-1:0] masks);
		logic [EID_W-1:0] m;
		m = '0;
		unique case (src)
			2'b00:         m = masks[0*EID_W +: EID_W]; // RL17
			2'b01:         m = masks[1*EID_W +: EID_W]; // RL17
			2'b10:         m = masks[2*EID_W +: EID_W]; // RL17
			MASK_SRC_NONE: m = '0; // RL17
		endcase
		return m;
	endfunction : pick_mask

	// clear-only update: a written zero clears, a written one keeps
	function automatic logic [15:0] clear_by_zero(input logic [15:0] cur, input logic [15:0] wdat);
		return cur & wdat;
	endfunction : clear_by_zero

	// --------------------
	// apb decode
	// --------------------
	logic        setup;
	logic        wr_en;
	logic [1:0]  pair_idx;
	logic        pair_hit;

	assign setup    = psel_i && !penable_i;
	assign wr_en    = psel_i && penable_i && pwrite_i;
	assign pair_hit = (paddr_i >= OFS_PAIR_CTL_0) && (paddr_i <= OFS_PAIR_CTL_3) && (paddr_i[1:0] == 2'b00);
	assign pair_idx = 2'(ADDR_W'(paddr_i - OFS_PAIR_CTL_0) >> 2);

	// --------------------
	// mask registers and mask source selection
	// --------------------
	logic [NUM_MASKS*EID_W-1:0] ext_id_mask_q;
	logic [31:0]                mask_sel_q;

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ext_id_mask_q <= {NUM_MASKS{RST_EXT_ID_MASK}};
			mask_sel_q    <= RST_MASK_SEL;
		end
		else if (wr_en)
		begin
			unique case (paddr_i)
				OFS_EXT_ID_MASK_0:   ext_id_mask_q[0*EID_W +: EID_W] <= pwdata_i[15:0]; // RL2
				OFS_EXT_ID_MASK_1:   ext_id_mask_q[1*EID_W +: EID_W] <= pwdata_i[15:0]; // RL2
				OFS_EXT_ID_MASK_2:   ext_id_mask_q[2*EID_W +: EID_W] <= pwdata_i[15:0]; // RL2
				OFS_MASK_SOURCE_SEL: mask_sel_q <= pwdata_i;
				default:             ;
			endcase
		end
	end

	// --------------------
	// acceptance comparison
	// --------------------
	logic [1:0]       acc_src;
	logic [EID_W-1:0] acc_mask;

	assign acc_src  = mask_sel_q[{acc_filter_idx_i, 1'b0} +: 2];
	assign acc_mask = pick_mask(acc_src, ext_id_mask_q);

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_done_o  <= 1'b0;
			acc_match_o <= 1'b0;
		end
		else
		begin
			acc_done_o  <= acc_valid_i;
			// only included bits are compared
			acc_match_o <= acc_valid_i && (((acc_id_i ^ acc_filter_eid_i) & acc_mask) == '0); // RL1 RL18
		end
	end

	// --------------------
	// receive full and overflow flags
	// --------------------
	logic [NUM_RX_BUFS-1:0] full_q;
	logic [NUM_RX_BUFS-1:0] ovf_q;
	logic [NUM_RX_BUFS-1:0] full_d;
	logic [NUM_RX_BUFS-1:0] ovf_d;
	logic                   store_into_full;

	assign store_into_full   = rx_store_i && full_q[rx_store_buf_i];
	// the engine writes DMA memory only while accepted, so a full buffer keeps its data
	assign rx_store_accept_o = !full_q[rx_store_buf_i]; // RL16 RL19

	always_comb
	begin
		full_d = full_q;
		ovf_d  = ovf_q;
		if (wr_en)
		begin
			unique case (paddr_i)
				OFS_RX_FULL_LOW:  full_d[15:0]  = clear_by_zero(full_q[15:0], pwdata_i[15:0]); // RL4
				OFS_RX_FULL_HIGH: full_d[31:16] = clear_by_zero(full_q[31:16], pwdata_i[15:0]); // RL4
				OFS_RX_OVF_LOW:   ovf_d[15:0]   = clear_by_zero(ovf_q[15:0], pwdata_i[15:0]); // RL4
				OFS_RX_OVF_HIGH:  ovf_d[31:16]  = clear_by_zero(ovf_q[31:16], pwdata_i[15:0]); // RL4
				default:          ;
			endcase
		end
		// hardware set follows the software clear so it wins
		if (rx_store_i)
		begin
			full_d[rx_store_buf_i] = 1'b1; // RL3
		end
		if (store_into_full)
		begin
			ovf_d[rx_store_buf_i] = 1'b1; // RL5
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			full_q <= {RST_FLAGS, RST_FLAGS};
			ovf_q  <= {RST_FLAGS, RST_FLAGS};
		end
		else
		begin
			full_q <= full_d;
			ovf_q  <= ovf_d;
		end
	end

	// --------------------
	// buffer pair control
	// --------------------
	logic [NUM_TR_BUFS-1:0]   dir_q;
	logic [NUM_TR_BUFS-1:0]   req_q;
	logic [NUM_TR_BUFS-1:0]   rtr_en_q;
	logic [NUM_TR_BUFS*2-1:0] pri_q;
	logic [NUM_TR_BUFS-1:0]   abt_q;
	logic [NUM_TR_BUFS-1:0]   larb_q;
	logic [NUM_TR_BUFS-1:0]   err_q;
	logic [NUM_TR_BUFS-1:0]   abort_q;
	logic [NUM_TR_BUFS-1:0]   req_d;
	logic [NUM_TR_BUFS-1:0]   abort_d;
	logic [NUM_TR_BUFS-1:0]   ctl_wr;
	logic [NUM_TR_BUFS-1:0]   ctl_wr_req;
	logic [NUM_TR_BUFS-1:0]   req_rise;
	logic [NUM_TR_BUFS-1:0]   tx_ev_hit;

	always_comb
	begin
		for (int i = 0; i < NUM_TR_BUFS; i++)
		begin
			// even buffer in the low byte, odd buffer in the high byte
			ctl_wr[i]     = wr_en && pair_hit && (pair_idx == 2'(i / 2)); // RL6
			ctl_wr_req[i] = pwdata_i[(i % 2) * 8 + CTL_REQ_BIT];
			tx_ev_hit[i]  = tx_event_i && (tx_event_buf_i == 3'(i));
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dir_q    <= RST_PAIR_CTL[NUM_TR_BUFS-1:0];
			rtr_en_q <= RST_PAIR_CTL[NUM_TR_BUFS-1:0];
			pri_q    <= RST_PAIR_CTL;
		end
		else
		begin
			for (int i = 0; i < NUM_TR_BUFS; i++)
			begin
				if (ctl_wr[i])
				begin
					dir_q[i]          <= pwdata_i[(i % 2) * 8 + CTL_DIR_BIT]; // RL7
					rtr_en_q[i]       <= pwdata_i[(i % 2) * 8 + CTL_RTR_BIT];
					pri_q[i*2 +: 2]   <= pwdata_i[(i % 2) * 8 + CTL_PRI_LSB +: 2];
				end
			end
		end
	end

	// send request and abort request
	always_comb
	begin
		req_d   = req_q;
		abort_d = abort_q;
		for (int i = 0; i < NUM_TR_BUFS; i++)
		begin
			if (ctl_wr[i])
			begin
				req_d[i] = ctl_wr_req[i];
				if (req_q[i] && !ctl_wr_req[i])
				begin
					abort_d[i] = 1'b1; // RL12
				end
			end
			// finished or aborted transmission ends the request
			if (tx_ev_hit[i] && (tx_event_kind_i == TX_EV_SUCCESS || tx_event_kind_i == TX_EV_ABORTED))
			begin
				req_d[i]   = 1'b0; // RL11
				abort_d[i] = 1'b0;
			end
			if (remote_rx_i && (remote_buf_i == 3'(i)) && rtr_en_q[i])
			begin
				req_d[i] = 1'b1; // RL13
			end
			req_rise[i] = req_d[i] && !req_q[i];
			if (req_rise[i])
			begin
				abort_d[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_q   <= RST_PAIR_CTL[NUM_TR_BUFS-1:0];
			abort_q <= RST_PAIR_CTL[NUM_TR_BUFS-1:0];
		end
		else
		begin
			req_q   <= req_d;
			abort_q <= abort_d;
		end
	end

	// read-only outcome flags; an event in the same cycle wins over the clear
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			abt_q  <= RST_PAIR_CTL[NUM_TR_BUFS-1:0];
			larb_q <= RST_PAIR_CTL[NUM_TR_BUFS-1:0];
			err_q  <= RST_PAIR_CTL[NUM_TR_BUFS-1:0];
		end
		else
		begin
			for (int i = 0; i < NUM_TR_BUFS; i++)
			begin
				if (req_rise[i])
				begin
					abt_q[i]  <= 1'b0; // RL15
					larb_q[i] <= 1'b0; // RL15
					err_q[i]  <= 1'b0; // RL15
				end
				if (tx_ev_hit[i])
				begin
					unique case (tx_event_kind_i)
						TX_EV_SUCCESS:   abt_q[i]  <= 1'b0; // RL8
						TX_EV_ABORTED:   abt_q[i]  <= 1'b1; // RL8
						TX_EV_LOST_ARB:  larb_q[i] <= 1'b1; // RL9
						TX_EV_BUS_ERROR: err_q[i]  <= 1'b1; // RL10
					endcase
				end
			end
		end
	end

	assign buf_is_tx_o = dir_q; // RL7
	assign abort_req_o = abort_q;

	// --------------------
	// transmit selection
	// --------------------
	logic       best_valid;
	logic [2:0] best_buf;
	logic [1:0] best_pri;

	// on equal priority the higher buffer number goes first
	always_comb
	begin
		best_valid = 1'b0;
		best_buf   = '0;
		best_pri   = '0;
		for (int i = 0; i < NUM_TR_BUFS; i++)
		begin
			if (req_q[i] && dir_q[i] && !abort_q[i] && (!best_valid || pri_q[i*2 +: 2] >= best_pri)) // RL14
			begin
				best_valid = 1'b1;
				best_buf   = 3'(i);
				best_pri   = pri_q[i*2 +: 2];
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_sel_valid_o <= 1'b0;
			tx_sel_buf_o   <= '0;
		end
		else
		begin
			tx_sel_valid_o <= best_valid;
			tx_sel_buf_o   <= best_buf;
		end
	end

	// --------------------
	// interrupt status and mask
	// --------------------
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_set;

	always_comb
	begin
		irq_set                = '0;
		irq_set[IRQ_RX_STORED] = rx_store_i && !full_q[rx_store_buf_i];
		irq_set[IRQ_RX_OVF]    = store_into_full;
		irq_set[IRQ_TX_DONE]   = tx_event_i && (tx_event_kind_i == TX_EV_SUCCESS);
		irq_set[IRQ_TX_ABT]    = tx_event_i && (tx_event_kind_i == TX_EV_ABORTED);
		irq_set[IRQ_TX_LARB]   = tx_event_i && (tx_event_kind_i == TX_EV_LOST_ARB);
		irq_set[IRQ_TX_ERR]    = tx_event_i && (tx_event_kind_i == TX_EV_BUS_ERROR);
	end

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
		end
		else
		begin
			if (wr_en && paddr_i == OFS_IRQ_MASK)
			begin
				irq_mask_q <= pwdata_i[IRQ_W-1:0];
			end
			if (wr_en && paddr_i == OFS_IRQ_STATUS)
			begin
				irq_stat_q <= (irq_stat_q & ~pwdata_i[IRQ_W-1:0]) | irq_set;
			end
			else
			begin
				irq_stat_q <= irq_stat_q | irq_set;
			end
		end
	end

	assign irq_o = |(irq_stat_q & irq_mask_q);

	// --------------------
	// read data
	// --------------------
	logic [31:0] rd_mux;
	logic        rd_err;
	logic [15:0] pair_word;

	always_comb
	begin
		for (int b = 0; b < 2; b++)
		begin
			pair_word[b*8 + CTL_DIR_BIT]      = dir_q[pair_idx*2 + b];
			pair_word[b*8 + CTL_ABT_BIT]      = abt_q[pair_idx*2 + b];
			pair_word[b*8 + CTL_LARB_BIT]     = larb_q[pair_idx*2 + b];
			pair_word[b*8 + CTL_ERR_BIT]      = err_q[pair_idx*2 + b];
			pair_word[b*8 + CTL_REQ_BIT]      = req_q[pair_idx*2 + b];
			pair_word[b*8 + CTL_RTR_BIT]      = rtr_en_q[pair_idx*2 + b];
			pair_word[b*8 + CTL_PRI_LSB +: 2] = pri_q[(pair_idx*2 + b)*2 +: 2];
		end
	end

	always_comb
	begin
		rd_mux = '0;
		rd_err = 1'b0;
		if (pair_hit)
		begin
			rd_mux = {16'h0000, pair_word}; // RL6
		end
		else
		begin
			unique case (paddr_i)
				OFS_EXT_ID_MASK_0:   rd_mux = {16'h0000, ext_id_mask_q[0*EID_W +: EID_W]};
				OFS_EXT_ID_MASK_1:   rd_mux = {16'h0000, ext_id_mask_q[1*EID_W +: EID_W]};
				OFS_EXT_ID_MASK_2:   rd_mux = {16'h0000, ext_id_mask_q[2*EID_W +: EID_W]};
				OFS_RX_FULL_LOW:     rd_mux = {16'h0000, full_q[15:0]};
				OFS_RX_FULL_HIGH:    rd_mux = {16'h0000, full_q[31:16]};
				OFS_RX_OVF_LOW:      rd_mux = {16'h0000, ovf_q[15:0]};
				OFS_RX_OVF_HIGH:     rd_mux = {16'h0000, ovf_q[31:16]};
				OFS_MASK_SOURCE_SEL: rd_mux = mask_sel_q;
				OFS_IRQ_STATUS:      rd_mux = {{(32-IRQ_W){1'b0}}, irq_stat_q};
				OFS_IRQ_MASK:        rd_mux = {{(32-IRQ_W){1'b0}}, irq_mask_q};
				default:             rd_err = 1'b1;
			endcase
		end
	end

	// captured in setup so the access phase answers from flip-flops
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata_o  <= '0;
			pslverr_o <= 1'b0;
		end
		else if (setup)
		begin
			prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_mux;
			pslverr_o <= rd_err;
		end
	end

	assign pready_o = psel_i && penable_i;

endmodule : can_buffer_status_tx_control

//--- verif/can_buf_ctl_checker.sv
// port assertions for the buffer status and transmit control block
`timescale 1ns/1ps
module can_buf_ctl_checker
	import can_buf_ctl_pkg::*;
(
	// clock, reset, bus
	input wire logic                   sys_clk_i,
	input wire logic                   rst_n_i,
	input wire logic                   psel_i,
	input wire logic                   penable_i,
	input wire logic                   pwrite_i,
	input wire logic [ADDR_W-1:0]      paddr_i,
	input wire logic [31:0]            prdata_o,
	input wire logic                   pslverr_o,
	// engine side
	input wire logic                   rx_store_i,
	input wire logic [4:0]             rx_store_buf_i,
	input wire logic                   rx_store_accept_o,
	input wire logic                   tx_sel_valid_o,
	input wire logic [2:0]             tx_sel_buf_o,
	input wire logic [NUM_TR_BUFS-1:0] buf_is_tx_o,
	input wire logic [NUM_TR_BUFS-1:0] abort_req_o,
	input wire logic                   acc_valid_i,
	input wire logic                   acc_done_o,
	input wire logic                   acc_match_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_store_sets_full: assert property (
		rx_store_i ##1 (rx_store_i && rx_store_buf_i == $past(rx_store_buf_i)) |-> !rx_store_accept_o)
		else $error("second store into a full buffer was accepted");
	a_acc_answer_next: assert property (acc_valid_i |=> acc_done_o)
		else $error("compare not answered in the next cycle");
	a_acc_no_spurious: assert property (!acc_valid_i |=> !acc_done_o && !acc_match_o)
		else $error("compare answer without a request");
	a_abort_from_write: assert property (
		(abort_req_o & ~$past(abort_req_o)) != '0 |-> $past(psel_i && penable_i && pwrite_i))
		else $error("abort raised without a register write");
	a_dir_from_write: assert property (
		buf_is_tx_o != $past(buf_is_tx_o) |-> $past(psel_i && penable_i && pwrite_i))
		else $error("direction changed without a register write");
	a_sel_is_tx: assert property (
		tx_sel_valid_o |-> (($past(buf_is_tx_o) >> tx_sel_buf_o) & 8'h01) != 8'h00)
		else $error("selected buffer is not a transmit buffer");
	a_sel_not_aborting: assert property (
		tx_sel_valid_o |-> (($past(abort_req_o) >> tx_sel_buf_o) & 8'h01) == 8'h00)
		else $error("aborting buffer still selected");
	a_unmapped_refused: assert property (
		psel_i && penable_i && paddr_i > OFS_IRQ_MASK |-> pslverr_o && prdata_o == 32'h0)
		else $error("unmapped access not refused");
endmodule : can_buf_ctl_checker

bind can_buffer_status_tx_control can_buf_ctl_checker u_can_buf_ctl_checker (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
	.rx_store_i(rx_store_i), .rx_store_buf_i(rx_store_buf_i), .rx_store_accept_o(rx_store_accept_o),
	.tx_sel_valid_o(tx_sel_valid_o), .tx_sel_buf_o(tx_sel_buf_o), .buf_is_tx_o(buf_is_tx_o),
	.abort_req_o(abort_req_o), .acc_valid_i(acc_valid_i), .acc_done_o(acc_done_o),
	.acc_match_o(acc_match_o));

//--- verif/can_bus_node_model.sv
// far-side engine model: stores, remote frames, transmit outcomes, compares
`timescale 1ns/1ps
module can_bus_node_model
(
	// clock
	input  wire logic sys_clk_i,
	// engine strobes and fields
	output logic        rx_store_o,
	output logic [4:0]  rx_store_buf_o,
	output logic        remote_rx_o,
	output logic [2:0]  remote_buf_o,
	output logic        tx_event_o,
	output logic [2:0]  tx_event_buf_o,
	output logic [1:0]  tx_event_kind_o,
	output logic        acc_valid_o,
	output logic [3:0]  acc_filter_idx_o,
	output logic [15:0] acc_filter_eid_o,
	output logic [15:0] acc_id_o
);
	initial
	begin
		{rx_store_o, rx_store_buf_o, remote_rx_o, remote_buf_o, tx_event_o} = '0;
		{tx_event_buf_o, tx_event_kind_o, acc_valid_o, acc_filter_idx_o} = '0;
		{acc_filter_eid_o, acc_id_o} = '0;
	end

	// idle fields carry junk, never the last value
	task automatic idle;
		{rx_store_o, remote_rx_o, tx_event_o, acc_valid_o} <= 4'h0;
		rx_store_buf_o <= ~rx_store_buf_o;
		remote_buf_o <= ~remote_buf_o;
		{tx_event_buf_o, tx_event_kind_o} <= ~{tx_event_buf_o, tx_event_kind_o};
		{acc_filter_idx_o, acc_filter_eid_o, acc_id_o} <= ~{acc_filter_idx_o, acc_filter_eid_o, acc_id_o};
		@(posedge sys_clk_i);
	endtask : idle

	task automatic store(input logic [4:0] b, input int n);
		rx_store_o <= 1'b1;
		rx_store_buf_o <= b;
		repeat (n) @(posedge sys_clk_i);
		idle();
	endtask : store

	task automatic remote(input logic [2:0] b);
		remote_rx_o <= 1'b1;
		remote_buf_o <= b;
		@(posedge sys_clk_i);
		idle();
	endtask : remote

	task automatic tx(input logic [2:0] b, input logic [1:0] k);
		tx_event_o <= 1'b1;
		tx_event_buf_o <= b;
		tx_event_kind_o <= k;
		@(posedge sys_clk_i);
		idle();
	endtask : tx

	task automatic acc(input logic [3:0] f, input logic [15:0] ext_identifier_bits, input logic [15:0] id);
		acc_valid_o <= 1'b1;
		{acc_filter_idx_o, acc_filter_eid_o, acc_id_o} <= {f, ext_identifier_bits, id};
		@(posedge sys_clk_i);
		idle();
	endtask : acc
endmodule : can_bus_node_model

//--- verif/tb.sv
// self-checking bench for the buffer status and transmit control block
`timescale 1ns/1ps
module tb;
	import can_buf_ctl_pkg::*;
	logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic        prdy, perr, rs, rs_acc, rm, te, av, ad, am, sv, irq;
	logic [4:0]  rsb;
	logic [2:0]  rmb, teb, sb;
	logic [1:0]  tek;
	logic [3:0]  af;
	logic [15:0] aeid, aid;
	logic [7:0]  istx, abr;
	logic [31:0] rq[$];
	logic        aq[$];
	int          bad_count = 0, cmp_count = 0, cyc = 0;

	always #50 clk = ~clk;

	can_buffer_status_tx_control u_can_buffer_status_tx_control (.sys_clk_i(clk), .rst_n_i(rst_n),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(prdy), .pslverr_o(perr), .rx_store_i(rs), .rx_store_buf_i(rsb),
		.rx_store_accept_o(rs_acc), .remote_rx_i(rm), .remote_buf_i(rmb), .tx_event_i(te),
		.tx_event_buf_i(teb), .tx_event_kind_i(tek), .tx_sel_valid_o(sv), .tx_sel_buf_o(sb),
		.buf_is_tx_o(istx), .abort_req_o(abr), .acc_valid_i(av), .acc_filter_idx_i(af),
		.acc_filter_eid_i(aeid), .acc_id_i(aid), .acc_done_o(ad), .acc_match_o(am), .irq_o(irq));
	can_bus_node_model u_can_bus_node_model (.sys_clk_i(clk), .rx_store_o(rs), .rx_store_buf_o(rsb),
		.remote_rx_o(rm), .remote_buf_o(rmb), .tx_event_o(te), .tx_event_buf_o(teb),
		.tx_event_kind_o(tek), .acc_valid_o(av), .acc_filter_idx_o(af), .acc_filter_eid_o(aeid),
		.acc_id_o(aid));

	// -----------------------------------------------------------------
	// tasks
	// -----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	// hold the request until pready is seen, one idle cycle after
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		{pwr, paddr, pwdata, pen} <= {w, a, d, 1'b0};
		@(posedge clk);
		pen <= 1'b1;
		do begin @(posedge clk); n++; end while (prdy !== 1'b1 && n < 50);
		{psel, pen} <= 2'b00;
		@(posedge clk);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd

	// -----------------------------------------------------------------
	// result monitor and hang guard
	// -----------------------------------------------------------------
	always @(posedge clk)
	begin
		if (psel && pen && prdy && !pwr)
			check(prdata, rq.pop_front(), "read");
		if (ad === 1'b1)
			check({31'h0, am}, {31'h0, aq.pop_front()}, "accept");
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			report_and_stop();
		end
	end

	initial
	begin
		logic [15:0] m[4];
		logic [31:0] d, full_e, ovf_e;
		logic [15:0] id, df;
		logic [4:0]  b;
		logic [1:0]  c;
		void'($urandom(32'had9bf33f));
		{full_e, ovf_e} = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int a = 0; a <= 8'h38; a += 4) rd(8'(a), 32'h0);
		$display("reset values done");
		for (int i = 0; i < 3; i++) begin d = $urandom; m[i] = d[15:0]; apb(1'b1, 8'(4 * i), d); end
		m[3] = 16'hffff;
		for (int i = 0; i < 3; i++) rd(8'(4 * i), {16'h0, m[i]});
		for (int k = 0; k < 8; k++)
		begin
			c = k[1:0];
			b = 5'($urandom_range(15));
			apb(1'b1, OFS_MASK_SOURCE_SEL, 32'(c) << (2 * b));
			id = 16'($urandom);
			df = k[2] ? 16'h1 << $urandom_range(15) : ~m[c];
			aq.push_back(c == 2'b11 || (df & m[c]) == 16'h0);
			u_can_bus_node_model.acc(b[3:0], id ^ df, id);
		end
		$display("acceptance done");
		for (int i = 0; i < 4; i++)
		begin
			b = {i[1], i[0] ? 4'hf : 4'h0};
			u_can_bus_node_model.store(b, 2);
			full_e[b] = 1'b1;
			ovf_e[b] = 1'b1;
		end
		for (int p = 0; p < 3; p++)
		begin
			if (p > 0) for (int r = 0; r < 4; r++) apb(1'b1, 8'(OFS_RX_FULL_LOW + 4 * r), p == 1 ? 32'hffff : 32'hff0000);
			if (p == 2) {full_e, ovf_e} = '0;
			rd(OFS_RX_FULL_LOW, {16'h0, full_e[15:0]});
			rd(OFS_RX_FULL_HIGH, {16'h0, full_e[31:16]});
			rd(OFS_RX_OVF_LOW, {16'h0, ovf_e[15:0]});
			rd(OFS_RX_OVF_HIGH, {16'h0, ovf_e[31:16]});
		end
		$display("receive flags done");
		apb(1'b1, OFS_PAIR_CTL_0, 32'h898b);
		rd(OFS_PAIR_CTL_0, 32'h898b);
		check({28'h0, sv, sb}, 32'h8, "priority");
		u_can_bus_node_model.tx(3'd0, TX_EV_LOST_ARB);
		u_can_bus_node_model.tx(3'd1, TX_EV_BUS_ERROR);
		rd(OFS_PAIR_CTL_0, 32'h99ab);
		u_can_bus_node_model.tx(3'd0, TX_EV_SUCCESS);
		rd(OFS_PAIR_CTL_0, 32'h99a3);
		apb(1'b1, OFS_PAIR_CTL_0, 32'h9b8b);
		rd(OFS_PAIR_CTL_0, 32'h9b8b);
		check({28'h0, sv, sb}, 32'h9, "tie");
		apb(1'b1, OFS_PAIR_CTL_0, 32'h9b83);
		rd(OFS_PAIR_CTL_0, 32'h9b83);
		check({24'h0, abr}, 32'h1, "abort");
		u_can_bus_node_model.tx(3'd0, TX_EV_ABORTED);
		rd(OFS_PAIR_CTL_0, 32'h9bc3);
		apb(1'b1, 8'h20, 32'h0084);
		u_can_bus_node_model.remote(3'd2);
		u_can_bus_node_model.remote(3'd3);
		rd(8'h20, 32'h008c);
		check({24'h0, istx}, 32'h7, "direction");
		$display("transmit control done");
		rd(OFS_IRQ_STATUS, 32'h3f);
		check({31'h0, irq}, 32'h0, "irq masked");
		apb(1'b1, OFS_IRQ_MASK, 32'h3f);
		check({31'h0, irq}, 32'h1, "irq raised");
		apb(1'b1, OFS_IRQ_STATUS, 32'h3f);
		rd(OFS_IRQ_STATUS, 32'h0);
		check({31'h0, irq}, 32'h0, "irq cleared");
		$display("interrupt done");
		repeat (4) @(posedge clk);
		report_and_stop();
	end
endmodule : tb
